//--- verilog/crb_rx_id_status.sv
// receive buffer filter-hit status and identifier registers, axi4-lite slave
//
// Overview of operation
// RULE1: legacy filter hit codes 0..5; 6,7 reserved
// RULE2: legacy codes 0,1 in buffer 1 need double-buffering
// RULE3: enhanced modes: five-bit hit index, filters 0..15
// RULE4: id high byte: sid10..3 or eid28..21
// RULE5: id low byte: id bits, srr, flag, eid17..16
// RULE6: extended-frame flag at id low bit 3
// RULE7: id low bit 2 reads zero
// RULE8: ext id high byte holds eid15..8, read-only
// RULE9: flag set for extended, clear for standard
// RULE10: srr zero if extended, else rtr flag
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crb_rx_id_status import crb_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // accepted message from the can receiver
  input wire logic msg_valid,
  input wire logic msg_extended,
  input wire logic msg_rtr,
  input wire logic [28:0] msg_id,
  input wire logic [4:0] msg_filter,
  // buffer status
  output logic buffer0_full,
  output logic buffer1_full,
  output logic msg_dropped
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic enh;             // enhanced mode
    logic dben;            // buffer0_double_buffer_enable
    logic full0;           // buffer 0 occupied
    logic full1;           // buffer 1 occupied
    logic rtr0;            // buffer 0 received_remote_request_flag
    logic rtr1;            // buffer 1 received_remote_request_flag
    logic [4:0] filt1;     // buffer 1 filter hit, all five bits
    logic [7:0] awaddr;    // latched write address
    logic aw_have;         // write address held
    logic [31:0] wdata;    // latched write data
    logic [3:0] wstrb;     // latched strobes
    logic w_have;          // write data held
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic load0;           // store strobe buffer 0
    logic load1;           // store strobe buffer 1
    logic ld_ext;          // stored frame type
    logic ld_rtr;          // stored rtr
    logic [28:0] ld_id;    // stored identifier
    logic dropped;         // message lost pulse
  } crb_state_t;

  crb_state_t state_reg;   // registered state
  crb_state_t state_next;  // next state

  // slot wiring
  crb_store_if st0 ();
  crb_store_if st1 ();
  logic [7:0] sidh0;
  logic [7:0] sidl0;
  logic [7:0] eidh0;
  logic [7:0] sidh1;
  logic [7:0] sidl1;
  logic [7:0] eidh1;

  // decode helpers
  logic filt_legal;        // code in range for mode
  logic to0;               // store into buffer 0
  logic to1;               // store into buffer 1
  logic do_write;          // both halves of a write held
  logic wr_hit;            // write address mapped
  logic [7:0] rd_byte;     // read byte
  logic rd_hit;            // read address mapped

  ////////////////////////////////////////////////////////////////////////////
  // buffer steering for an accepted message
  always_comb begin
    to0 = 1'b0;
    to1 = 1'b0;
    if (state_reg.enh) begin
      filt_legal = (msg_filter <= ENH_FILT_MAX); // RULE3
    end else begin
      filt_legal = (msg_filter <= LEGACY_FILT_MAX); // RULE1
    end
    if (msg_valid && filt_legal) begin
      if (state_reg.enh) begin
        // first free buffer
        if (!state_reg.full0) begin
          to0 = 1'b1;
        end else if (!state_reg.full1) begin
          to1 = 1'b1;
        end
      end else if (msg_filter >= DBL_FILT_LIMIT) begin
        // filters 2..5 belong to buffer 1
        to1 = !state_reg.full1; // RULE1
      end else if (!state_reg.full0) begin
        to0 = 1'b1;
      end else if (state_reg.dben && !state_reg.full1) begin
        // overflow from buffer 0 only when double-buffered
        to1 = 1'b1; // RULE2
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = RST_BYTE;
    if (s_axi_araddr == OFS_MODE) begin
      rd_byte[MODE_ENH_BIT] = state_reg.enh;
    end else if (s_axi_araddr == OFS_RXB0CTL) begin
      rd_byte[CTL_FULL_BIT] = state_reg.full0;
      rd_byte[CTL_RTR_BIT] = state_reg.rtr0;
      rd_byte[CTL_DBEN_BIT] = state_reg.dben;
    end else if (s_axi_araddr == OFS_RXB1CTL) begin
      rd_byte[CTL_FULL_BIT] = state_reg.full1;
      rd_byte[CTL_RTR_BIT] = state_reg.rtr1;
      rd_byte[2:0] = state_reg.filt1[2:0]; // RULE1 RULE3
    end else if (s_axi_araddr == OFS_RXB1UP) begin
      // upper bits only meaningful in enhanced modes
      if (state_reg.enh) begin
        rd_byte[UP_LSB+1:UP_LSB] = state_reg.filt1[4:3]; // RULE3
      end
    end else if (s_axi_araddr == OFS_SIDH0) begin
      rd_byte = sidh0;
    end else if (s_axi_araddr == OFS_SIDL0) begin
      rd_byte = sidl0;
    end else if (s_axi_araddr == OFS_EIDH0) begin
      rd_byte = eidh0;
    end else if (s_axi_araddr == OFS_SIDH1) begin
      rd_byte = sidh1;
    end else if (s_axi_araddr == OFS_SIDL1) begin
      rd_byte = sidl1;
    end else if (s_axi_araddr == OFS_EIDH1) begin
      rd_byte = eidh1;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // only the three control offsets take writes
  assign wr_hit = (state_reg.awaddr == OFS_MODE) || (state_reg.awaddr == OFS_RXB0CTL)
    || (state_reg.awaddr == OFS_RXB1CTL);
  assign do_write = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.load0 = to0;
    state_next.load1 = to1;
    state_next.dropped = msg_valid && !to0 && !to1;
    if (to0 || to1) begin
      state_next.ld_ext = msg_extended; // RULE9
      state_next.ld_rtr = msg_rtr && !msg_extended; // RULE10
      state_next.ld_id = msg_id;
    end
    // write channel capture
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.awaddr = s_axi_awaddr;
      state_next.aw_have = 1'b1;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
      state_next.w_have = 1'b1;
    end
    // software clears of full flags, hardware set wins below
    if (do_write) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (state_reg.wstrb[0]) begin
        if (state_reg.awaddr == OFS_MODE) begin
          state_next.enh = state_reg.wdata[MODE_ENH_BIT];
        end else if (state_reg.awaddr == OFS_RXB0CTL) begin
          state_next.dben = state_reg.wdata[CTL_DBEN_BIT];
          if (!state_reg.wdata[CTL_FULL_BIT]) begin
            state_next.full0 = 1'b0;
          end
        end else if (state_reg.awaddr == OFS_RXB1CTL) begin
          if (!state_reg.wdata[CTL_FULL_BIT]) begin
            state_next.full1 = 1'b0;
          end
        end
      end
    end else if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // message store sets flags, and the filter hit for buffer 1 only
    if (to0) begin
      state_next.full0 = 1'b1;
      state_next.rtr0 = msg_rtr;
    end
    if (to1) begin
      state_next.full1 = 1'b1;
      state_next.rtr1 = msg_rtr;
      state_next.filt1 = msg_filter; // RULE1 RULE2 RULE3
    end
    state_next.awready = !state_next.aw_have && !state_next.bvalid;
    state_next.wready = !state_next.w_have && !state_next.bvalid;
    // read channel
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = {24'h000000, rd_byte};
      state_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.filt1 <= FILT_RST;
      state_reg.bresp <= RESP_OKAY;
      state_reg.rresp <= RESP_OKAY;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // identifier slots
  assign st0.load = state_reg.load0;
  assign st0.extended = state_reg.ld_ext;
  assign st0.rtr = state_reg.ld_rtr;
  assign st0.id = state_reg.ld_id;
  assign st1.load = state_reg.load1;
  assign st1.extended = state_reg.ld_ext;
  assign st1.rtr = state_reg.ld_rtr;
  assign st1.id = state_reg.ld_id;

  crb_id_slot u_slot0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .st(st0),
    .sidh(sidh0),
    .sidl(sidl0),
    .eidh(eidh0)
  );

  crb_id_slot u_slot1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .st(st1),
    .sidh(sidh1),
    .sidl(sidl1),
    .eidh(eidh1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign buffer0_full = state_reg.full0;
  assign buffer1_full = state_reg.full1;
  assign msg_dropped = state_reg.dropped;
endmodule
`default_nettype wire

//--- verilog/crb_pkg.sv
// constants and types shared by the receive-buffer identifier/status block
package crb_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;      // mode control
  localparam logic [7:0] OFS_RXB0CTL = 8'h04;   // rx_buffer0_control
  localparam logic [7:0] OFS_RXB1CTL = 8'h08;   // rx_buffer1_control
  localparam logic [7:0] OFS_RXB1UP = 8'h0C;    // upper filter hit bits
  localparam logic [7:0] OFS_SIDH0 = 8'h10;     // buffer 0 std id high
  localparam logic [7:0] OFS_SIDL0 = 8'h14;     // buffer 0 std id low
  localparam logic [7:0] OFS_EIDH0 = 8'h18;     // buffer 0 ext id high
  localparam logic [7:0] OFS_SIDH1 = 8'h20;     // buffer 1 std id high
  localparam logic [7:0] OFS_SIDL1 = 8'h24;     // buffer 1 std id low
  localparam logic [7:0] OFS_EIDH1 = 8'h28;     // buffer 1 ext id high
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MODE_ENH_BIT = 0;   // enhanced mode select
  localparam int CTL_FULL_BIT = 7;   // buffer holds a message
  localparam int CTL_RTR_BIT = 3;    // received remote request
  localparam int CTL_DBEN_BIT = 2;   // double buffer enable (buffer 0)
  localparam int UP_LSB = 3;         // upper filter hit field lsb
  ////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] FILT_RST = 5'h00;
  localparam logic [4:0] LEGACY_FILT_MAX = 5'h05;  // filters 0..5
  localparam logic [4:0] ENH_FILT_MAX = 5'h0F;     // filters 0..15
  localparam logic [4:0] DBL_FILT_LIMIT = 5'h02;   // codes below use buffer 0
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  ////////////////////////////////////////////////////////////////////////////
  // identifier bytes of one buffer
  typedef struct packed {
    logic [7:0] sidh;
    logic [7:0] sidl;
    logic [7:0] eidh;
  } crb_slot_t;
endpackage

//--- verilog/crb_store_if.sv
// carrier of one message store from the control logic into an id slot
`timescale 1ns/100ps
`default_nettype none
interface crb_store_if;
  logic load;         // one-cycle store strobe
  logic extended;     // message is an extended frame
  logic rtr;          // received remote request flag
  logic [28:0] id;    // identifier, standard in bits 10:0
  modport src (output load, output extended, output rtr, output id);
  modport dst (input load, input extended, input rtr, input id);
endinterface
`default_nettype wire

//--- verilog/crb_id_slot.sv
// identifier bytes of one receive buffer, formatted by frame type
`timescale 1ns/100ps
`default_nettype none
module crb_id_slot import crb_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // store from control logic
  crb_store_if.dst st,
  // formatted bytes
  output logic [7:0] sidh,
  output logic [7:0] sidl,
  output logic [7:0] eidh
);
  crb_slot_t state_reg;  // registered bytes
  crb_slot_t state_next; // next bytes

  ////////////////////////////////////////////////////////////////////////////
  // format bytes on store
  always_comb begin
    state_next = state_reg;
    if (st.load) begin
      if (st.extended) begin
        state_next.sidh = st.id[28:21]; // RULE4
        // srr zero, flag set, bit 2 zero
        state_next.sidl = {st.id[20:18], 1'b0, 1'b1, 1'b0, st.id[17:16]}; // RULE5 RULE6 RULE7 RULE9 RULE10
        state_next.eidh = st.id[15:8]; // RULE8
      end else begin
        state_next.sidh = st.id[10:3]; // RULE4
        // srr follows rtr, flag clear, bit 2 zero
        state_next.sidl = {st.id[2:0], st.rtr, 1'b0, 1'b0, 2'h0}; // RULE5 RULE6 RULE7 RULE9 RULE10
        state_next.eidh = RST_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '{sidh: RST_BYTE, sidl: RST_BYTE, eidh: RST_BYTE};
    end else begin
      state_reg <= state_next;
    end
  end

  assign sidh = state_reg.sidh; // read only
  assign sidl = state_reg.sidl; // RULE6 RULE7 RULE9 RULE10
  assign eidh = state_reg.eidh;
endmodule
`default_nettype wire

//--- testbench/crb_rx_id_status_properties.sv
// port assertions for the rx id and status block
`timescale 1ns/100ps
`default_nettype none
module crb_rx_id_status_properties import crb_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // message side
  input wire logic msg_valid,
  input wire logic [4:0] msg_filter,
  input wire logic buffer0_full,
  input wire logic msg_dropped
);
  logic [7:0] ra_reg; // address of the read in flight
  logic lo_rd; // answer is an id low byte
  // capture read address at its handshake
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra_reg <= s_axi_araddr;
    end
  end
  assign lo_rd = s_axi_rvalid && s_axi_rresp == RESP_OKAY && (ra_reg == OFS_SIDL0 || ra_reg == OFS_SIDL1);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  byte_only_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("rdata high bits");
  low_bit2_a: assert property (lo_rd |-> !s_axi_rdata[2]) else $error("id low bit 2 set");
  ext_srr_a: assert property (lo_rd && s_axi_rdata[3] |-> !s_axi_rdata[4]) else $error("srr set");
  std_low_a: assert property (lo_rd && !s_axi_rdata[3] |-> s_axi_rdata[1:0] == 2'b00) else $error("std low");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  range_drop_a: assert property (msg_valid && msg_filter > ENH_FILT_MAX |=> msg_dropped)
    else $error("no drop");
  buf0_take_a: assert property (msg_valid && !buffer0_full && msg_filter < DBL_FILT_LIMIT
    |=> buffer0_full && !msg_dropped) else $error("buffer 0 not taken");
  drop_cause_a: assert property (msg_dropped |-> $past(msg_valid)) else $error("drop without message");
  // main scenarios reached
  cover property (msg_valid ##1 msg_dropped);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  cover property (lo_rd && s_axi_rdata[3]);
endmodule
bind crb_rx_id_status crb_rx_id_status_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .msg_valid(msg_valid), .msg_filter(msg_filter),
  .buffer0_full(buffer0_full), .msg_dropped(msg_dropped));
`default_nettype wire

//--- testbench/crb_can_node.sv
// remote can node: hands accepted messages to the block
`timescale 1ns/100ps
`default_nettype none
module crb_can_node (
  // clock
  input wire logic aclk,
  // accepted message
  output logic msg_valid,
  output logic msg_extended,
  output logic msg_rtr,
  output logic [28:0] msg_id,
  output logic [4:0] msg_filter
);
  // idle lines at time zero
  initial begin
    msg_valid = 1'b0;
    msg_extended = 1'b0;
    msg_rtr = 1'b0;
    msg_id = 29'h00000000;
    msg_filter = 5'h00;
  end
  // one message for one cycle, then the id and filter lines flip
  task automatic send(input logic x, input logic r, input logic [28:0] id, input logic [4:0] f);
    @(posedge aclk);
    msg_valid <= 1'b1;
    msg_extended <= x;
    msg_rtr <= r;
    msg_id <= id;
    msg_filter <= f;
    @(posedge aclk);
    msg_valid <= 1'b0;
    msg_id <= ~id;
    msg_filter <= ~f;
  endtask
endmodule
`default_nettype wire

//--- testbench/crb_rx_id_status_test.sv
// bench: register reads, message steering and refusals
`timescale 1ns/100ps
`default_nettype none
module crb_rx_id_status_test import crb_pkg::*; ;
  // bench signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, mv, mx, mr, full0, full1, dropped;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [28:0] mid;
  logic [4:0] mf;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  crb_rx_id_status uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .msg_valid(mv), .msg_extended(mx), .msg_rtr(mr), .msg_id(mid),
    .msg_filter(mf), .buffer0_full(full0), .buffer1_full(full1), .msg_dropped(dropped));
  crb_can_node node (.aclk(aclk), .msg_valid(mv), .msg_extended(mx), .msg_rtr(mr), .msg_id(mid),
    .msg_filter(mf));
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // compare one result
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_d;
    logic w_d;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (wready) begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask
  // axi4-lite read
  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    check(rdata, {24'h000000, ed});
    check({30'h0, rresp}, {30'h0, er});
  endtask
  // one message, then the drop pulse
  task automatic send(input logic x, input logic r, input logic [28:0] id, input logic [4:0] f, input logic dr);
    node.send(x, r, id, f);
    #1;
    check({31'h0, dropped}, {31'h0, dr});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped and read-only places
  task automatic t_regs();
    rd(OFS_MODE, 8'h00, RESP_OKAY);
    rd(OFS_RXB1CTL, 8'h00, RESP_OKAY);
    rd(OFS_RXB1UP, 8'h00, RESP_OKAY);
    rd(8'h40, 8'h00, RESP_SLVERR);
    wr(8'h40, 8'h01, RESP_SLVERR);
    wr(OFS_EIDH0, 8'hFF, RESP_SLVERR);
    rd(OFS_EIDH0, 8'h00, RESP_OKAY);
  endtask
  // codes 2..5 land in buffer 1, bytes follow the frame type
  task automatic t_frames();
    logic [28:0] id;
    logic x;
    logic r;
    for (int f = 2; f < 6; f++) begin
      x = f[0];
      r = f[1];
      id = x ? 29'h1ABCDEF5 : 29'h000005A3;
      send(x, r, id, f[4:0], 1'b0);
      check({31'h0, full1}, 32'h1);
      // a full buffer 1 refuses the next message and keeps the stored one
      send(!x, !r, ~id, f[4:0], 1'b1);
      rd(OFS_SIDH1, x ? id[28:21] : id[10:3], RESP_OKAY);
      rd(OFS_SIDL1, x ? {id[20:18], 3'b010, id[17:16]} : {id[2:0], r, 4'h0}, RESP_OKAY);
      rd(OFS_EIDH1, x ? id[15:8] : 8'h00, RESP_OKAY);
      rd(OFS_RXB1CTL, {4'h8, r, f[2:0]}, RESP_OKAY);
      wr(OFS_RXB1CTL, 8'h00, RESP_OKAY);
      check({31'h0, full1}, 32'h0);
    end
  endtask
  // reserved codes are not stored
  task automatic t_reserved();
    for (int f = 6; f < 8; f++) begin
      send(1'b0, 1'b0, 29'h00000123, f[4:0], 1'b1);
      check({31'h0, full1}, 32'h0);
    end
  endtask
  // code 1 reaches buffer 1 only with double buffering
  task automatic t_double();
    send(1'b0, 1'b0, 29'h00000111, 5'h00, 1'b0);
    check({31'h0, full0}, 32'h1);
    send(1'b0, 1'b0, 29'h00000222, 5'h01, 1'b1);
    wr(OFS_RXB0CTL, 8'h84, RESP_OKAY);
    rd(OFS_RXB0CTL, 8'h84, RESP_OKAY);
    send(1'b0, 1'b0, 29'h00000333, 5'h01, 1'b0);
    rd(OFS_RXB1CTL, 8'h81, RESP_OKAY);
    rd(OFS_SIDH1, 8'h66, RESP_OKAY);
    wr(OFS_RXB0CTL, 8'h00, RESP_OKAY);
    wr(OFS_RXB1CTL, 8'h00, RESP_OKAY);
  endtask
  // enhanced mode: five-bit index up to filter 15
  task automatic t_enh();
    wr(OFS_MODE, 8'h01, RESP_OKAY);
    send(1'b0, 1'b0, 29'h00000444, 5'h0D, 1'b0);
    check({31'h0, full0}, 32'h1);
    send(1'b1, 1'b0, 29'h0ABCDEF0, 5'h0F, 1'b0);
    // both buffers full: refused, filter hit unchanged
    send(1'b0, 1'b0, 29'h00000666, 5'h02, 1'b1);
    rd(OFS_RXB1CTL, 8'h87, RESP_OKAY);
    rd(OFS_RXB1UP, 8'h08, RESP_OKAY);
    wr(OFS_RXB1CTL, 8'h00, RESP_OKAY);
    send(1'b0, 1'b0, 29'h00000555, 5'h10, 1'b1);
    check({31'h0, full1}, 32'h0);
  endtask
  // main sequence
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frames();
    t_reserved();
    t_double();
    t_enh();
    close_out();
  end
endmodule
`default_nettype wire
